/* src/epc_div_if.sv */
// divider ratio and tick between the pin block and its divider
// assumes both ends run on the one system clock
`timescale 1ns/1ps
`default_nettype none
interface epc_div_if;
    logic [2:0] ratio;
    logic       tick;
    modport src (input ratio, output tick);
    modport usr (output ratio, input tick);
endinterface
`default_nettype wire

/* src/epc_pin_ctl.sv */
// external bus pin control: address drive, clock pins, buffer strobes,
// dma request synchronisers, axi4-lite registers
// assumes bus cycle inputs and pins are synchronous to i_sys_clk
// Functional notes
// - With the strap high, the disable-address bits of the low and top region registers decide address drive on the muxed bus.
// - An enabled cycle presents its memory address on the twenty address pins.
// - With the strap low, address and data are always driven on the muxed bus.
// - The strap is sampled one cycle after device reset releases and held until the next reset.
// - Clock pin A is off, crystal rate or divided rate by the power-save fields.
// - Clock pin A keeps running through reset and bus hold.
// - Clock pin B is off, pll rate or divided rate by the power-save fields.
// - Clock pin B keeps running through reset and bus hold.
// - The buffer enable goes low in memory, io and acknowledge cycles and high on a direction change.
// - The buffer enable floats during bus hold and reset.
// - The dma requests are level inputs, synchronised, never latched.
// - Direction is high to transmit and low to receive.
// - Direction floats during reset and bus hold.
// - With the strap high, a set disable-address bit withholds the address for every cycle with its select active, overlaps included.
`timescale 1ns/1ps
`default_nettype none
module epc_pin_ctl (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst,
    input  wire logic [epc_pkg::AXI_AW-1:0] i_awaddr,
    input  wire logic                   i_awvalid,
    output var  logic                   o_awready,
    input  wire logic [31:0]            i_wdata,
    input  wire logic [3:0]             i_wstrb,
    input  wire logic                   i_wvalid,
    output var  logic                   o_wready,
    output var  logic [1:0]             o_bresp,
    output var  logic                   o_bvalid,
    input  wire logic                   i_bready,
    input  wire logic [epc_pkg::AXI_AW-1:0] i_araddr,
    input  wire logic                   i_arvalid,
    output var  logic                   o_arready,
    output var  logic [31:0]            o_rdata,
    output var  logic [1:0]             o_rresp,
    output var  logic                   o_rvalid,
    input  wire logic                   i_rready,
    input  wire logic                   i_dev_reset,
    input  wire logic                   i_hold_grant,
    input  wire logic                   i_addr_strap,
    input  wire logic                   i_cyc_valid,
    input  wire epc_pkg::epc_kind_t     i_cyc_kind,
    input  wire logic                   i_cyc_write,
    input  wire logic                   i_cyc_low_sel,
    input  wire logic                   i_cyc_top_sel,
    input  wire logic [19:0]            i_cyc_addr,
    input  wire logic                   i_dma_request_ch0,
    input  wire logic                   i_dma_request_ch1,
    output var  logic [19:0]            o_addr,
    output var  logic                   o_ad_addr_en,
    output var  logic                   o_clka,
    output var  logic                   o_clka_oe,
    output var  logic                   o_clkb,
    output var  logic                   o_clkb_oe,
    output var  logic                   o_buf_en_n,
    output var  logic                   o_buf_en_oe,
    output var  logic                   o_data_direction,
    output var  logic                   o_data_direction_oe,
    output var  logic                   o_dma_req0,
    output var  logic                   o_dma_req1
);
    import epc_pkg::*;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [15:0] low_reg;
        logic [15:0] top_reg;
        logic [15:0] ps_reg;
        logic        strap;
        logic        res_q;
        logic        pend;
        logic [1:0]  dma1;
        logic [1:0]  dma2;
        logic [19:0] addr;
        logic        ad_en;
        logic        den_n;
        logic        den_oe;
        logic        dir;
        logic        dir_oe;
        logic        clka;
        logic        clka_oe;
        logic        clkb;
        logic        clkb_oe;
    } epc_st_t;

    epc_st_t   st;
    epc_st_t   next_st;
    epc_div_if div_if ();

    epc_psdiv #(.CNT_W(8)) u_div (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .div       (div_if.src)
    );
    assign div_if.ratio = st.ps_reg[DIV_LSB +: DIV_W];

    function automatic logic [15:0] wmerge(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
        logic [15:0] r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_LOW || a == OFS_TOP || a == OFS_PSAVE ||
               a == OFS_STAT;
    endfunction

    // returns {oe, level} of a clock pin for the next cycle
    function automatic logic [1:0] clk_next(input logic [1:0] sel,
                                            input logic cur,
                                            input logic tick);
        logic [1:0] r;
        r = {1'b0, cur};
        case (epc_csel_t'(sel))
            CS_BASE: r = {1'b1, ~cur};
            CS_DIV:  r = {1'b1, tick ? ~cur : cur};
            default: r = {1'b0, cur};
        endcase
        return r;
    endfunction

    logic        busy;
    logic [15:0] rd_val;
    logic        low_da;
    logic        top_da;

    always_comb begin
        busy   = i_dev_reset || i_hold_grant;
        low_da = st.low_reg[DA_BIT];
        top_da = st.top_reg[DA_BIT];
        case (i_araddr)
            OFS_LOW:   rd_val = st.low_reg;
            OFS_TOP:   rd_val = st.top_reg;
            OFS_PSAVE: rd_val = st.ps_reg;
            OFS_STAT: begin
                rd_val = '0;
                rd_val[ST_STRAP] = st.strap;
                rd_val[ST_DMA0] = st.dma2[0];
                rd_val[ST_DMA1] = st.dma2[1];
                rd_val[ST_DIR] = st.dir;
                rd_val[ST_BUSY] = busy;
            end
            default:   rd_val = '0;
        endcase

        next_st = st;
        // axi write address and data, either order
        if (i_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = i_awaddr;
        end
        if (i_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = i_wdata;
            next_st.wstrb = i_wstrb;
        end
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = is_mapped(st.aw_addr) ? RESP_OKAY
                                                  : RESP_SLVERR;
            case (st.aw_addr)
                OFS_LOW:   next_st.low_reg =
                    wmerge(st.low_reg, st.wdata, st.wstrb);
                OFS_TOP:   next_st.top_reg =
                    wmerge(st.top_reg, st.wdata, st.wstrb);
                OFS_PSAVE: next_st.ps_reg =
                    wmerge(st.ps_reg, st.wdata, st.wstrb);
                default: ;
            endcase
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;
        // axi read
        if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (i_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = {16'h0000, rd_val};
            next_st.rresp = is_mapped(i_araddr) ? RESP_OKAY
                                                : RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;

        // strap capture one cycle after reset release
        next_st.res_q = i_dev_reset;
        next_st.pend = st.res_q && !i_dev_reset;
        if (st.pend) begin
            next_st.strap = i_addr_strap;
        end

        // dma request synchronisers, level only
        next_st.dma1 = {i_dma_request_ch1, i_dma_request_ch0};
        next_st.dma2 = st.dma1;

        // clock pins run regardless of reset and hold
        {next_st.clka_oe, next_st.clka} = clk_next(
            st.ps_reg[CLKA_LSB +: 2], st.clka, div_if.tick);
        {next_st.clkb_oe, next_st.clkb} = clk_next(
            st.ps_reg[CLKB_LSB +: 2], st.clkb, div_if.tick);

        // buffer enable, direction and address pins
        next_st.den_oe = !busy;
        next_st.dir_oe = !busy;
        next_st.den_n = 1'b1;
        if (i_cyc_valid && !busy) begin
            next_st.dir = i_cyc_write;
            next_st.addr = i_cyc_addr;
            next_st.ad_en = !(st.strap &&
                ((i_cyc_low_sel && low_da) ||
                 (i_cyc_top_sel && top_da)));
            next_st.den_n = (i_cyc_write != st.dir) ||
                            (i_cyc_kind == CK_NONE);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.low_reg <= LOW_RST;
            st.top_reg <= TOP_RST;
            st.ps_reg <= PSAVE_RST;
            st.strap <= STRAP_RST;
            st.ad_en <= 1'b1;
            st.den_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_awready = st.awready;
    assign o_wready = st.wready;
    assign o_bresp = st.bresp;
    assign o_bvalid = st.bvalid;
    assign o_arready = st.arready;
    assign o_rdata = st.rdata;
    assign o_rresp = st.rresp;
    assign o_rvalid = st.rvalid;
    assign o_addr = st.addr;
    assign o_ad_addr_en = st.ad_en;
    assign o_clka = st.clka;
    assign o_clka_oe = st.clka_oe;
    assign o_clkb = st.clkb;
    assign o_clkb_oe = st.clkb_oe;
    assign o_buf_en_n = st.den_n;
    assign o_buf_en_oe = st.den_oe;
    assign o_data_direction = st.dir;
    assign o_data_direction_oe = st.dir_oe;
    assign o_dma_req0 = st.dma2[0];
    assign o_dma_req1 = st.dma2[1];

    // checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    property p_strap_cap;
        $fell(i_dev_reset) ##1 1'b1 |=> st.strap == $past(i_addr_strap);
    endproperty
    a_strap_cap: assert property (p_strap_cap)
        else $error("strap not captured after reset release");

    property p_strap_keep;
        !st.pend |=> $stable(st.strap);
    endproperty
    a_strap_keep: assert property (p_strap_keep)
        else $error("strap changed outside capture");

    property p_full_ad;
        st.strap == 1'b0 && i_cyc_valid && !busy |=> o_ad_addr_en;
    endproperty
    a_full_ad: assert property (p_full_ad)
        else $error("address withheld with strap low");

    property p_da_block;
        st.strap && i_cyc_valid && !busy &&
        ((i_cyc_low_sel && low_da) || (i_cyc_top_sel && top_da))
        |=> !o_ad_addr_en;
    endproperty
    a_da_block: assert property (p_da_block)
        else $error("address driven despite disable bit");

    property p_addr;
        i_cyc_valid && !busy |=> o_addr == $past(i_cyc_addr);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address pins do not follow cycle");

    property p_clka_run;
        st.ps_reg[CLKA_LSB +: 2] == CS_BASE ##1
        st.ps_reg[CLKA_LSB +: 2] == CS_BASE
        |=> o_clka_oe && o_clka != $past(o_clka);
    endproperty
    a_clka_run: assert property (p_clka_run)
        else $error("clock a stalled");

    property p_clkb_off;
        st.ps_reg[CLKB_LSB +: 2] inside {CS_OFF, CS_OFF2}
        |=> !o_clkb_oe;
    endproperty
    a_clkb_off: assert property (p_clkb_off)
        else $error("clock b not tristated");

    property p_float;
        busy |=> !o_buf_en_oe && !o_data_direction_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("strobes driven in reset or hold");

    property p_dir_chg;
        $changed(o_data_direction) |-> o_buf_en_n;
    endproperty
    a_dir_chg: assert property (p_dir_chg)
        else $error("buffer enabled across direction change");

    property p_dma_sync;
        ##2 1'b1 |-> o_dma_req0 == $past(i_dma_request_ch0, 2);
    endproperty
    a_dma_sync: assert property (p_dma_sync)
        else $error("dma request not two-stage synchronised");

    c_write: cover property (st.bvalid && i_bready);
    c_read: cover property (st.rvalid && i_rready);
    c_da: cover property (!o_ad_addr_en);
    c_div: cover property (o_clka_oe && div_if.tick &&
                           st.ps_reg[CLKA_LSB +: 2] == CS_DIV);
endmodule // epc_pin_ctl
`default_nettype wire

/* src/epc_pkg.sv */
// constants for the external bus pin control block
// assumes a single 40 MHz clock and an axi4-lite register port
package epc_pkg;
    localparam int          AXI_AW      = 8;
    localparam int          REG_W       = 16;
    // register byte offsets
    localparam logic [7:0]  OFS_LOW     = 8'h00;
    localparam logic [7:0]  OFS_TOP     = 8'h04;
    localparam logic [7:0]  OFS_PSAVE   = 8'h08;
    localparam logic [7:0]  OFS_STAT    = 8'h0C;
    // field positions
    localparam int          DA_BIT      = 7;
    localparam int          CLKA_LSB    = 8;
    localparam int          CLKB_LSB    = 10;
    localparam int          DIV_LSB     = 0;
    localparam int          DIV_W       = 3;
    localparam int          ST_STRAP    = 0;
    localparam int          ST_DMA0     = 1;
    localparam int          ST_DMA1     = 2;
    localparam int          ST_DIR      = 3;
    localparam int          ST_BUSY     = 4;
    // reset values
    localparam logic [15:0] LOW_RST     = 16'h0000;
    localparam logic [15:0] TOP_RST     = 16'h0000;
    localparam logic [15:0] PSAVE_RST   = 16'h0000;
    localparam logic        STRAP_RST   = 1'h1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // clock pin source select
    typedef enum logic [1:0] {
        CS_BASE = 2'b00,
        CS_DIV  = 2'b01,
        CS_OFF  = 2'b10,
        CS_OFF2 = 2'b11
    } epc_csel_t;
    // kind of the current bus cycle
    typedef enum logic [1:0] {
        CK_MEM  = 2'b00,
        CK_IO   = 2'b01,
        CK_INTA = 2'b10,
        CK_NONE = 2'b11
    } epc_kind_t;
endpackage

/* src/epc_psdiv.sv */
// power-save divider: one-cycle tick every 2**ratio cycles
// assumes ratio is steady between ticks
`timescale 1ns/1ps
`default_nettype none
module epc_psdiv #(
    parameter int CNT_W = 8
) (
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst,
    epc_div_if.src      div
);
    import epc_pkg::*;
    if (CNT_W < (1 << DIV_W) - 1) begin : g_bad_w
        $error("epc_psdiv: CNT_W too small");
    end
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } epc_div_st_t;
    epc_div_st_t st;
    epc_div_st_t next_st;
    logic [CNT_W-1:0] limit;
    always_comb begin
        limit   = CNT_W'((1 << div.ratio) - 1);
        next_st = st;
        if (st.cnt >= limit) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt  = st.cnt + CNT_W'(1);
            next_st.tick = 1'b0;
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign div.tick = st.tick;
endmodule // epc_psdiv
`default_nettype wire

/* verif/epc_dma_peer.sv */
// dma requesting peripherals: raise a request, hold it until served
// assumes start and served pulses come from the bench on the system clock
`timescale 1ns/1ps
`default_nettype none
module epc_dma_peer (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_start,
    input  wire logic [1:0] i_served,
    output var  logic [1:0] o_req
);
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_req <= 2'h0;
        end else begin
            o_req <= (o_req | i_start) & ~i_served;
        end
    end
endmodule // epc_dma_peer
`default_nettype wire

/* verif/ext_bus_pin_control_tb_top.sv */
// self-checking bench for the external bus pin control block
// assumes the epc_pkg constants and a 40 MHz system clock
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pin_control_tb_top;
    import epc_pkg::*;
    logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_dev_reset = 1'b1;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [3:0]  i_wstrb = 4'h0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp, dma_req;
    logic [1:0]  peer_start = 2'h0, peer_served = 2'h0;
    logic        i_hold_grant = 1'b0, i_addr_strap = 1'b1;
    logic        i_cyc_valid = 1'b0;
    epc_kind_t   i_cyc_kind = CK_NONE;
    logic        i_cyc_write = 1'b0, i_cyc_low_sel = 1'b0;
    logic        i_cyc_top_sel = 1'b0;
    logic [19:0] i_cyc_addr = 20'h0, o_addr;
    logic        o_ad_addr_en, o_clka, o_clka_oe, o_clkb, o_clkb_oe;
    logic        o_buf_en_n, o_buf_en_oe, o_data_direction;
    logic        o_data_direction_oe, o_dma_req0, o_dma_req1;
    int          n_errors = 0;
    int          checked = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    epc_dma_peer peer_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_start(peer_start), .i_served(peer_served), .o_req(dma_req));

    epc_pin_ctl dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready),
        .i_dev_reset(i_dev_reset), .i_hold_grant(i_hold_grant),
        .i_addr_strap(i_addr_strap), .i_cyc_valid(i_cyc_valid),
        .i_cyc_kind(i_cyc_kind), .i_cyc_write(i_cyc_write),
        .i_cyc_low_sel(i_cyc_low_sel), .i_cyc_top_sel(i_cyc_top_sel),
        .i_cyc_addr(i_cyc_addr), .i_dma_request_ch0(dma_req[0]),
        .i_dma_request_ch1(dma_req[1]), .o_addr(o_addr),
        .o_ad_addr_en(o_ad_addr_en), .o_clka(o_clka), .o_clka_oe(o_clka_oe),
        .o_clkb(o_clkb), .o_clkb_oe(o_clkb_oe), .o_buf_en_n(o_buf_en_n),
        .o_buf_en_oe(o_buf_en_oe), .o_data_direction(o_data_direction),
        .o_data_direction_oe(o_data_direction_oe),
        .o_dma_req0(o_dma_req0), .o_dma_req1(o_dma_req1));

    task complete_run;
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    task timed_out;
        n_errors++;
        complete_run;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        int k;
        @(posedge i_sys_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge i_sys_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1) begin
                chk(o_bresp, er);
                i_bready <= 1'b0;
                break;
            end
        end
        if (k == 40) timed_out;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        @(posedge i_sys_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge i_sys_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1) begin
                chk(o_rdata, ed);
                chk(o_rresp, er);
                i_rready <= 1'b0;
                break;
            end
        end
        if (k == 40) timed_out;
    endtask

    // one bus cycle, then pin state one edge later
    task cyc(input epc_kind_t k, input logic w, lo, tp,
             input logic [19:0] a, input logic en, bn);
        @(posedge i_sys_clk);
        i_cyc_valid <= 1'b1;
        i_cyc_kind <= k;
        i_cyc_write <= w;
        i_cyc_low_sel <= lo;
        i_cyc_top_sel <= tp;
        i_cyc_addr <= a;
        @(posedge i_sys_clk);
        i_cyc_valid <= 1'b0;
        #1;
        chk(o_addr, a);
        chk(o_ad_addr_en, en);
        chk(o_buf_en_n, bn);
        chk(o_data_direction, w);
        chk({o_buf_en_oe, o_data_direction_oe}, 2'b11);
    endtask

    // count clock pin toggles while driven
    task tog(input int n, input int ea, input int eb);
        int k, a, b;
        logic pa, pb;
        @(posedge i_sys_clk);
        #1;
        pa = o_clka;
        pb = o_clkb;
        a = 0;
        b = 0;
        for (k = 0; k < n; k++) begin
            @(posedge i_sys_clk);
            #1;
            if (o_clka_oe === 1'b1 && o_clka !== pa) a++;
            if (o_clkb_oe === 1'b1 && o_clkb !== pb) b++;
            pa = o_clka;
            pb = o_clkb;
        end
        chk(a, ea);
        chk(b, eb);
    endtask

    task t_regs;
        rd(OFS_LOW, 32'h0, RESP_OKAY);
        rd(OFS_TOP, 32'h0, RESP_OKAY);
        rd(OFS_PSAVE, 32'h0, RESP_OKAY);
        rd(OFS_STAT, 32'h1, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'hFFFF, 4'hF, RESP_SLVERR);
        wr(OFS_STAT, 32'hFF, 4'hF, RESP_OKAY);
        rd(OFS_STAT, 32'h1, RESP_OKAY);
        wr(OFS_LOW, 32'h1234_0080, 4'hF, RESP_OKAY);
        rd(OFS_LOW, 32'h80, RESP_OKAY);
        wr(OFS_TOP, 32'h0000_0180, 4'h2, RESP_OKAY);
        rd(OFS_TOP, 32'h100, RESP_OKAY);
    endtask

    task t_addr;
        cyc(CK_MEM, 1'b0, 1'b1, 1'b0, 20'hABCDE, 1'b0, 1'b0);
        cyc(CK_MEM, 1'b0, 1'b0, 1'b1, 20'h12345, 1'b1, 1'b0);
        cyc(CK_MEM, 1'b0, 1'b1, 1'b1, 20'hFFFFF, 1'b0, 1'b0);
        cyc(CK_MEM, 1'b0, 1'b0, 1'b0, 20'h00001, 1'b1, 1'b0);
        wr(OFS_TOP, 32'h80, 4'h1, RESP_OKAY);
        cyc(CK_IO, 1'b0, 1'b0, 1'b1, 20'h80000, 1'b0, 1'b0);
    endtask

    task t_dir;
        cyc(CK_MEM, 1'b1, 1'b0, 1'b0, 20'h00010, 1'b1, 1'b1);
        cyc(CK_IO, 1'b1, 1'b0, 1'b0, 20'h00020, 1'b1, 1'b0);
        cyc(CK_INTA, 1'b1, 1'b0, 1'b0, 20'h00030, 1'b1, 1'b0);
        cyc(CK_NONE, 1'b1, 1'b0, 1'b0, 20'h00040, 1'b1, 1'b1);
        cyc(CK_INTA, 1'b0, 1'b0, 1'b0, 20'h00050, 1'b1, 1'b1);
        cyc(CK_MEM, 1'b0, 1'b0, 1'b0, 20'h00060, 1'b1, 1'b0);
    endtask

    task t_hold;
        int m;
        for (m = 0; m < 2; m++) begin
            @(posedge i_sys_clk);
            if (m == 0) i_hold_grant <= 1'b1;
            else i_dev_reset <= 1'b1;
            tick(2);
            #1;
            chk(o_buf_en_oe, 1'b0);
            chk(o_data_direction_oe, 1'b0);
            tog(8, 8, 8);
            @(posedge i_sys_clk);
            i_hold_grant <= 1'b0;
            i_dev_reset <= 1'b0;
            tick(4);
        end
    endtask

    task t_strap;
        @(posedge i_sys_clk);
        i_dev_reset <= 1'b1;
        i_addr_strap <= 1'b0;
        tick(3);
        i_dev_reset <= 1'b0;
        tick(4);
        i_addr_strap <= 1'b1;
        rd(OFS_STAT, 32'h0, RESP_OKAY);
        cyc(CK_MEM, 1'b0, 1'b1, 1'b1, 20'h55555, 1'b1, 1'b0);
        @(posedge i_sys_clk);
        i_dev_reset <= 1'b1;
        tick(3);
        i_dev_reset <= 1'b0;
        tick(4);
        cyc(CK_MEM, 1'b0, 1'b1, 1'b0, 20'h0AAAA, 1'b0, 1'b0);
    endtask

    task t_clk;
        logic [15:0] pv [4];
        int          ea [4];
        int          eb [4];
        logic [1:0]  oe [4];
        int          i;
        pv = '{16'h0501, 16'h0602, 16'h0B00, 16'h0000};
        ea = '{8, 0, 0, 16};
        eb = '{8, 4, 0, 16};
        oe = '{2'b11, 2'b01, 2'b00, 2'b11};
        for (i = 0; i < 4; i++) begin
            wr(OFS_PSAVE, {16'h0, pv[i]}, 4'h3, RESP_OKAY);
            tick(3);
            tog(16, ea[i], eb[i]);
            chk({o_clka_oe, o_clkb_oe}, oe[i]);
        end
    endtask

    task t_dma;
        int c;
        for (c = 0; c < 2; c++) begin
            @(posedge i_sys_clk);
            peer_start <= 2'b01 << c;
            @(posedge i_sys_clk);
            peer_start <= 2'b00;
            @(posedge i_sys_clk);
            #1;
            chk({o_dma_req1, o_dma_req0}, 2'b00);
            @(posedge i_sys_clk);
            #1;
            chk({o_dma_req1, o_dma_req0}, 2'b01 << c);
            rd(OFS_STAT, 32'h1 | (32'h2 << c), RESP_OKAY);
            @(posedge i_sys_clk);
            peer_served <= 2'b01 << c;
            @(posedge i_sys_clk);
            peer_served <= 2'b00;
            @(posedge i_sys_clk);
            #1;
            chk({o_dma_req1, o_dma_req0}, 2'b01 << c);
            @(posedge i_sys_clk);
            #1;
            chk({o_dma_req1, o_dma_req0}, 2'b00);
        end
    endtask

    initial begin
        tick(5);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        i_dev_reset <= 1'b0;
        tick(4);
        t_regs;
        t_addr;
        t_dir;
        t_hold;
        t_strap;
        t_clk;
        t_dma;
        complete_run;
    end
endmodule // ext_bus_pin_control_tb_top
`default_nettype wire
